// file: shared/scif_evt_if.sv
// valid/ready event carrier between block modules
`timescale 1ns/1ns
`default_nettype none
interface scif_evt_if;
  import scif_pkg::*;
  logic      valid;
  logic      ready;
  scif_evt_e code;
  modport src (output valid, output code, input ready);
  modport snk (input valid, input code, output ready);
endinterface : scif_evt_if
`default_nettype wire

// file: shared/scif_map.svh
// constants of the smart card interface control block
`ifndef SCIF_MAP_SVH
`define SCIF_MAP_SVH
// ****************************************
// timing
// ****************************************
`define SCIF_CLOCK_NS    8
`define SCIF_STEP_NS     1000
`define SCIF_STEP_CYC    ((`SCIF_STEP_NS + `SCIF_CLOCK_NS - 1) / `SCIF_CLOCK_NS)
// ****************************************
// clock ratio codes {ratio_select_a, ratio_select_b}
// ****************************************
`define SCIF_RATIO_DIV8  2'h0
`define SCIF_RATIO_DIV4  2'h1
`define SCIF_RATIO_DIV1  2'h2
`define SCIF_RATIO_DIV2  2'h3
// ****************************************
// line layout and widths
// ****************************************
`define SCIF_LINES       3
`define SCIF_LINE_DATA   0
`define SCIF_LINE_AUX_A  1
`define SCIF_LINE_AUX_B  2
`define SCIF_SYNC_W      19
`define SCIF_SYNC_IDLE   19'h5023F
`define SCIF_EVT_W       3
`endif

// file: shared/scif_pkg.sv
// types of the smart card interface control block
package scif_pkg;
  typedef enum logic [3:0] {
    ST_OFF, ST_RAMP, ST_IO, ST_CLK, ST_ON,
    ST_DRST, ST_DCLK, ST_DIO, ST_DVCC, ST_HOLD
  } scif_seq_e;
  typedef enum logic [1:0] {RLY_IDLE, RLY_H2C, RLY_C2H, RLY_SETTLE} scif_relay_e;
  typedef enum logic [2:0] {
    EV_CARD_IN, EV_CARD_OUT, EV_VOLT_FAULT, EV_THERM_FAULT,
    EV_CURR_FAULT, EV_ACTIVE, EV_DEACTIVE
  } scif_evt_e;
endpackage : scif_pkg

// file: sim/scif_card.sv
// behavioural smart card in the reader slot
`timescale 1ns/1ns
`default_nettype none
module scif_card (
  input  wire logic       i_clock,
  input  wire logic       i_inserted,
  input  wire logic       i_switch_neg,
  input  wire logic       i_supply_on,
  input  wire logic       i_card_reset,
  input  wire logic [2:0] i_pull,
  input  wire logic [7:0] i_answer_delay,
  output logic            o_presence_pos,
  output logic            o_presence_neg_n,
  output logic [2:0]      o_pull
);
  logic [7:0] cnt = 8'h0;
  logic       rst_d = 1'b0;
  logic       live;
  // one switch reports, the unused one sits at its pull level
  assign o_presence_pos   = i_inserted && !i_switch_neg;
  assign o_presence_neg_n = !(i_inserted && i_switch_neg);
  assign live = i_inserted && i_supply_on;
  // answer to reset: data low six cycles after the delay
  always @(posedge i_clock) begin
    rst_d <= i_card_reset;
    if (!live) cnt <= 8'h0;
    else if (i_card_reset && !rst_d) cnt <= i_answer_delay + 8'h6;
    else if (cnt != 8'h0) cnt <= cnt - 8'h1;
  end
  // unpowered card pulls nothing, lines go to their pull-ups
  assign o_pull = live ? (i_pull | {2'h0, cnt != 8'h0 && cnt <= 8'h6}) : 3'h0;
endmodule // scif_card
`default_nettype wire

// file: sim/scif_chk.sv
// port assertions of the smart card interface control top
`timescale 1ns/1ns
`default_nettype none
module scif_chk (
  input wire logic       i_clock,
  input wire logic       i_rst_n,
  input wire logic       i_supply_command_n,
  input wire logic       i_card_reset_command,
  input wire logic       i_card_clock_halt,
  input wire logic       i_halt_level_select,
  input wire logic       i_presence_switch_pos,
  input wire logic       i_presence_switch_neg_n,
  input wire logic       i_voltage_fault,
  input wire logic       i_thermal_fault,
  input wire logic       i_overcurrent_fault,
  input wire logic [2:0] o_host_lines_oe,
  input wire logic [2:0] o_card_lines_oe,
  input wire logic       o_card_supply_on,
  input wire logic       o_card_reset,
  input wire logic       o_card_clock,
  input wire logic       o_interrupt_n_oe,
  input wire logic       o_event_valid,
  input wire logic [2:0] o_event_code,
  input wire logic       i_event_ready
);
  // ****
  // helpers
  // ****
  logic       presence_switch;
  logic       flt;
  logic [2:0] up_cnt;
  logic [4:0] on_cnt;
  assign presence_switch = i_presence_switch_pos || !i_presence_switch_neg_n;
  assign flt  = i_voltage_fault || i_thermal_fault || i_overcurrent_fault || !presence_switch;
  // cycles since reset release
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) up_cnt <= 3'h0;
    else if (up_cnt != 3'h7) up_cnt <= up_cnt + 3'h1;
  end
  // cycles of card supply on
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) on_cnt <= 5'h0;
    else if (!o_card_supply_on) on_cnt <= 5'h0;
    else if (on_cnt != 5'h1F) on_cnt <= on_cnt + 5'h1;
  end
  // ****
  // assertions
  // ****
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  supply_start_a: assert property (
    up_cnt == 3'h7 && $rose(o_card_supply_on) |->
    !$past(i_supply_command_n, 3) && $past(presence_switch, 3)) else $error("supply without request");
  card_idle_a: assert property (
    !o_card_supply_on |-> !o_card_clock && !o_card_reset) else $error("card active unpowered");
  halt_low_a: assert property (
    (i_card_clock_halt && !i_halt_level_select)[*5] |-> !$rose(o_card_clock))
    else $error("clock rose while halted");
  reset_follow_a: assert property (
    $rose(o_card_reset) |-> $past(i_card_reset_command, 3)) else $error("reset uncommanded");
  irq_card_a: assert property (
    (i_supply_command_n && presence_switch)[*4] ##0 up_cnt == 3'h7 |-> !o_interrupt_n_oe)
    else $error("idle interrupt with card");
  irq_none_a: assert property (
    (i_supply_command_n && !presence_switch)[*4] ##0 up_cnt == 3'h7 |-> o_interrupt_n_oe)
    else $error("no interrupt without card");
  fault_off_a: assert property (
    on_cnt == 5'h1F && !i_supply_command_n && $rose(flt) ##1 (!i_supply_command_n)[*5]
    |-> o_interrupt_n_oe ##[1:40] !o_card_supply_on) else $error("fault not handled");
  relay_excl_a: assert property (
    (o_card_lines_oe & o_host_lines_oe) == 3'h0) else $error("line pulled both sides");
  event_hold_a: assert property (
    o_event_valid && !i_event_ready |=> o_event_valid && $stable(o_event_code))
    else $error("stalled event lost");
  cover property ($rose(o_card_supply_on));
  cover property (i_card_clock_halt && o_card_clock && o_card_supply_on);
  cover property ($fell(o_card_supply_on) && o_interrupt_n_oe);
  cover property (o_event_valid && !i_event_ready);
endmodule // scif_chk
`default_nettype wire

// file: sim/scif_top_tb.sv
// self-checking bench of the smart card interface control top
`timescale 1ns/1ns
`default_nettype none
bind scif_top scif_chk u_chk (.*);
module scif_top_tb;
  import scif_pkg::*;
  // {ratio a, ratio b, voltage select, card clock period in cycles}
  localparam logic [10:0] ROWS [4] = '{{3'h1, 8'h50}, {3'h2, 8'h28}, {3'h7, 8'h14}, {3'h4, 8'h0A}};
  logic       clock = 1'b0, rst_n = 1'b0, cmd_n = 1'b1, rcmd = 1'b0, vsel = 1'b1;
  logic       halt = 1'b0, lvl = 1'b0, ra = 1'b0, rb = 1'b0, osc = 1'b0, ins = 1'b1;
  logic       neg_sw = 1'b0, ready = 1'b1, supply, v5, crst, cclk, irq_oe, pos, neg_n, ev_valid;
  logic [2:0] flt = 3'h0, hpull = 3'h0, cpull = 3'h0, host_oe, card_oe, card_pull;
  logic [2:0] host_lines, card_lines, ev_code;
  logic [7:0] p;
  logic [6:0] orv;
  logic       andc;
  int         fails = 0, n_checks = 0, cycles = 0, i, k;
  // ****
  // clocks, wires, instances
  // ****
  always #4 clock = ~clock;
  initial begin
    #3;
    forever #40 osc = ~osc;
  end
  assign host_lines = ~(host_oe | hpull);
  assign card_lines = ~(card_oe | card_pull);
  scif_top #(.STEP_CYCLES(4)) dut (
    .i_clock(clock), .i_rst_n(rst_n), .i_supply_command_n(cmd_n),
    .i_card_reset_command(rcmd), .i_card_voltage_select(vsel), .i_card_clock_halt(halt),
    .i_halt_level_select(lvl), .i_ratio_select_a(ra), .i_ratio_select_b(rb),
    .i_oscillator_input(osc), .i_presence_switch_pos(pos), .i_presence_switch_neg_n(neg_n),
    .i_voltage_fault(flt[0]), .i_thermal_fault(flt[1]), .i_overcurrent_fault(flt[2]),
    .i_host_lines(host_lines), .o_host_lines(), .o_host_lines_oe(host_oe),
    .i_card_lines(card_lines), .o_card_lines(), .o_card_lines_oe(card_oe),
    .o_card_supply_on(supply), .o_card_voltage_5v(v5), .o_card_reset(crst),
    .o_card_clock(cclk), .o_interrupt_n(), .o_interrupt_n_oe(irq_oe),
    .o_event_valid(ev_valid), .o_event_code(ev_code), .i_event_ready(ready));
  scif_card card (.i_clock(clock), .i_inserted(ins), .i_switch_neg(neg_sw),
    .i_supply_on(supply), .i_card_reset(crst), .i_pull(cpull), .i_answer_delay(8'h20),
    .o_presence_pos(pos), .o_presence_neg_n(neg_n), .o_pull(card_pull));
  // ****
  // tasks
  // ****
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic session(input logic on);
    cmd_n = !on;
    step(24);
  endtask
  task automatic watch(input int n);
    orv = 7'h0;
    andc = 1'b1;
    repeat (n) begin
      @(negedge clock);
      orv |= {cclk, host_oe, card_oe};
      andc &= cclk;
    end
  endtask
  task automatic period;
    logic prev;
    int rises;
    p = 8'h0;
    rises = 0;
    prev = cclk;
    repeat (200) begin
      @(negedge clock);
      if (cclk && !prev) rises++;
      if (rises == 1) p++;
      prev = cclk;
    end
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 6000) begin
      fails++;
      $display("mismatch at %0t: timeout", $time);
      finish_test();
    end
  end
  // ****
  // tests
  // ****
  initial begin
    step(5);
    check(8'({supply, v5, crst, cclk, irq_oe, ev_valid}), 8'h10, "reset outputs");
    step(5);
    rst_n = 1'b1;
    step(5);
    $display("test reset done");
    for (i = 0; i < 4; i++) begin
      {ra, rb, vsel} = ROWS[i][10:8];
      session(1'b1);
      check(8'(supply), 8'h1, "supply on");
      check(8'(v5), 8'(ROWS[i][8]), "card voltage");
      period();
      check(p, ROWS[i][7:0], "clock period");
      session(1'b0);
      check(8'(supply), 8'h0, "supply off");
      $display("test ratio row %0d done", i);
    end
    ins = 1'b0;
    step(5);
    check(8'(irq_oe), 8'h1, "no card irq");
    cmd_n = 1'b0;
    step(30);
    check(8'(supply), 8'h0, "no card no supply");
    cmd_n = 1'b1;
    ins = 1'b1;
    neg_sw = 1'b1;
    step(5);
    check(8'(irq_oe), 8'h0, "negative switch");
    neg_sw = 1'b0;
    session(1'b1);
    check(8'(supply), 8'h1, "positive switch");
    $display("test presence done");
    rcmd = 1'b1;
    watch(60);
    check(8'(crst), 8'h1, "card reset");
    check(8'(orv[3]), 8'h1, "answer relayed");
    for (k = 0; k < 3; k++) begin
      hpull = 3'(1 << k);
      watch(8);
      check(8'(orv[5:0]), 8'(1 << k), "host to card");
      hpull = 3'h0;
      step(8);
      cpull = 3'(1 << k);
      watch(8);
      check(8'(orv[5:0]), 8'(8 << k), "card to host");
      cpull = 3'h0;
      step(8);
    end
    halt = 1'b1;
    lvl = 1'b1;
    step(6);
    watch(30);
    check(8'(andc), 8'h1, "halted high");
    lvl = 1'b0;
    step(6);
    watch(30);
    check(8'(orv[6]), 8'h0, "halted low");
    halt = 1'b0;
    watch(100);
    check(8'(orv[6]), 8'h1, "clock resumes");
    $display("test session done");
    session(1'b0);
    step(10);
    ready = 1'b0;
    for (k = 0; k < 4; k++) begin
      session(1'b1);
      step(12);
      if (k < 3) flt = 3'(1 << k);
      else ins = 1'b0;
      step(30);
      check(8'({irq_oe, supply}), 8'h2, "fault shutdown");
      flt = 3'h0;
      ins = 1'b1;
      session(1'b0);
    end
    check(8'({ev_valid, ev_code}), 8'({1'b1, EV_ACTIVE}), "stalled event");
    ready = 1'b1;
    p = 8'h0;
    repeat (10) begin
      if (ev_valid === 1'b1) p++;
      step(1);
    end
    check(p, 8'h3, "events held");
    check(8'(ev_valid), 8'h0, "events drained");
    $display("test faults and events done");
    finish_test();
  end
endmodule // scif_top_tb
`default_nettype wire

// file: verilog/scif_buf.sv
// two-entry event buffer with valid and ready on both sides
`timescale 1ns/1ns
`default_nettype none
module scif_buf
  import scif_pkg::*;
(
  input  wire logic i_clock,
  input  wire logic i_rst_n,
  scif_evt_if.snk   in_evt,
  scif_evt_if.src   out_evt
);
  scif_evt_e  data0_reg;
  scif_evt_e  data1_reg;
  logic [1:0] count_reg;
  logic       push;
  logic       pop;

  assign in_evt.ready  = (count_reg != 2'h2);
  assign out_evt.valid = (count_reg != 2'h0);
  assign out_evt.code  = data0_reg;
  assign push          = in_evt.valid && in_evt.ready;
  assign pop           = out_evt.valid && out_evt.ready;

  // ****************************************
  // storage
  // ****************************************
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count_reg <= 2'h0;
      data0_reg <= EV_CARD_IN;
      data1_reg <= EV_CARD_IN;
    end else begin
      count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
      if (pop) begin
        data0_reg <= (push && count_reg == 2'h1) ? in_evt.code : data1_reg;
      end else if (push && count_reg == 2'h0) begin
        data0_reg <= in_evt.code;
      end
      if (push && ((count_reg == 2'h1 && !pop) || (count_reg == 2'h2))) begin
        data1_reg <= in_evt.code;
      end
    end
  end
endmodule : scif_buf
`default_nettype wire

// file: verilog/scif_clkdiv.sv
// card clock divider with halt level
`timescale 1ns/1ns
`default_nettype none
`include "scif_map.svh"
module scif_clkdiv
  import scif_pkg::*;
(
  input  wire logic       i_clock,
  input  wire logic       i_rst_n,
  input  wire logic       i_osc,
  input  wire logic [1:0] i_ratio,
  input  wire logic       i_enable,
  input  wire logic       i_halt,
  input  wire logic       i_halt_level,
  output logic            o_card_clock
);
  logic       osc_prev_reg;
  logic [1:0] cnt_reg;
  logic       tgl_reg;
  logic       rise;
  logic       term;

  assign rise = i_osc && !osc_prev_reg;
  always_comb begin
    unique case (i_ratio)
      `SCIF_RATIO_DIV8: term = (cnt_reg == 2'h3);
      `SCIF_RATIO_DIV4: term = cnt_reg[0];
      `SCIF_RATIO_DIV2: term = 1'b1;
      `SCIF_RATIO_DIV1: term = 1'b1;
    endcase
  end

  // ****************************************
  // divider
  // ****************************************
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      osc_prev_reg <= 1'b0;
      cnt_reg      <= 2'h0;
      tgl_reg      <= 1'b0;
    end else begin
      osc_prev_reg <= i_osc;
      if (!i_enable) begin
        cnt_reg <= 2'h0;
        tgl_reg <= 1'b0;
      end else if (rise) begin
        cnt_reg <= term ? 2'h0 : cnt_reg + 2'h1;
        tgl_reg <= term ? !tgl_reg : tgl_reg;
      end
    end
  end

  // ****************************************
  // output
  // ****************************************
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_card_clock <= 1'b0;
    end else if (!i_enable) begin
      o_card_clock <= 1'b0;
    end else if (i_halt) begin
      o_card_clock <= i_halt_level;
    end else if (i_ratio == `SCIF_RATIO_DIV1) begin
      o_card_clock <= i_osc;
    end else begin
      o_card_clock <= tgl_reg;
    end
  end
endmodule : scif_clkdiv
`default_nettype wire

// file: verilog/scif_top.sv
// smart card interface control: sequencer, relays, clock, interrupt, events
`timescale 1ns/1ns
`default_nettype none
`include "scif_map.svh"
module scif_top
  import scif_pkg::*;
#(
  parameter int unsigned STEP_CYCLES = `SCIF_STEP_CYC
) (
  input  wire logic                   i_clock,
  input  wire logic                   i_rst_n,
  input  wire logic                   i_supply_command_n,
  input  wire logic                   i_card_reset_command,
  input  wire logic                   i_card_voltage_select,
  input  wire logic                   i_card_clock_halt,
  input  wire logic                   i_halt_level_select,
  input  wire logic                   i_ratio_select_a,
  input  wire logic                   i_ratio_select_b,
  input  wire logic                   i_oscillator_input,
  input  wire logic                   i_presence_switch_pos,
  input  wire logic                   i_presence_switch_neg_n,
  input  wire logic                   i_voltage_fault,
  input  wire logic                   i_thermal_fault,
  input  wire logic                   i_overcurrent_fault,
  input  wire logic [`SCIF_LINES-1:0] i_host_lines,
  output logic      [`SCIF_LINES-1:0] o_host_lines,
  output logic      [`SCIF_LINES-1:0] o_host_lines_oe,
  input  wire logic [`SCIF_LINES-1:0] i_card_lines,
  output logic      [`SCIF_LINES-1:0] o_card_lines,
  output logic      [`SCIF_LINES-1:0] o_card_lines_oe,
  output logic                        o_card_supply_on,
  output logic                        o_card_voltage_5v,
  output logic                        o_card_reset,
  output logic                        o_card_clock,
  output logic                        o_interrupt_n,
  output logic                        o_interrupt_n_oe,
  output logic                        o_event_valid,
  output logic      [`SCIF_EVT_W-1:0] o_event_code,
  input  wire logic                   i_event_ready
);
  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [`SCIF_SYNC_W-1:0] sync1_reg;
  logic [`SCIF_SYNC_W-1:0] sync2_reg;

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync1_reg <= `SCIF_SYNC_IDLE;
      sync2_reg <= `SCIF_SYNC_IDLE;
    end else begin
      sync1_reg <= {i_supply_command_n, i_card_reset_command, i_card_voltage_select,
                    i_card_clock_halt, i_halt_level_select, i_ratio_select_a,
                    i_ratio_select_b, i_oscillator_input, i_presence_switch_pos,
                    i_presence_switch_neg_n, i_voltage_fault, i_thermal_fault,
                    i_overcurrent_fault, i_host_lines, i_card_lines};
      sync2_reg <= sync1_reg;
    end
  end

  logic                   cmd_n;
  logic                   rst_cmd;
  logic                   vsel;
  logic                   halt;
  logic                   halt_lvl;
  logic [1:0]             ratio;
  logic                   osc;
  logic                   presence_switch_pos;
  logic                   presence_switch_neg_n;
  logic                   volt_flt;
  logic                   therm_flt;
  logic                   curr_flt;
  logic [`SCIF_LINES-1:0] host_in;
  logic [`SCIF_LINES-1:0] card_in;

  assign {cmd_n, rst_cmd, vsel, halt, halt_lvl, ratio, osc, presence_switch_pos, presence_switch_neg_n,
          volt_flt, therm_flt, curr_flt, host_in, card_in} = sync2_reg;

  // ****************************************
  // presence and faults
  // ****************************************
  logic present;
  logic any_flt;
  logic present_prev_reg;

  assign present = presence_switch_pos || !presence_switch_neg_n;
  assign any_flt = volt_flt || therm_flt || curr_flt || !present;

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      present_prev_reg <= 1'b0;
    end else begin
      present_prev_reg <= present;
    end
  end

  // ****************************************
  // activation and deactivation sequencer
  // ****************************************
  scif_seq_e   state_reg;
  scif_seq_e   state_next;
  logic [15:0] timer_reg;
  logic        step_done;
  logic        in_session;
  logic        fault_hit;
  logic        fault_reg;

  assign step_done  = (timer_reg == 16'h0000);
  assign in_session = (state_reg == ST_RAMP) || (state_reg == ST_IO) ||
                      (state_reg == ST_CLK) || (state_reg == ST_ON);
  assign fault_hit  = in_session && any_flt;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_OFF:  if (!cmd_n && present) state_next = ST_RAMP;
      ST_RAMP: if (cmd_n || fault_hit) state_next = ST_DVCC;
               else if (step_done) state_next = ST_IO;
      ST_IO:   if (cmd_n || fault_hit) state_next = ST_DIO;
               else if (step_done) state_next = ST_CLK;
      ST_CLK:  if (cmd_n || fault_hit) state_next = ST_DCLK;
               else if (step_done) state_next = ST_ON;
      ST_ON:   if (cmd_n || fault_hit) state_next = ST_DRST;
      ST_DRST: if (step_done) state_next = ST_DCLK;
      ST_DCLK: if (step_done) state_next = ST_DIO;
      ST_DIO:  if (step_done) state_next = ST_DVCC;
      ST_DVCC: if (step_done) state_next = cmd_n ? ST_OFF : ST_HOLD;
      ST_HOLD: if (cmd_n) state_next = ST_OFF;
    endcase
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= ST_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      timer_reg <= 16'h0000;
    end else if (state_next != state_reg) begin
      timer_reg <= 16'(STEP_CYCLES - 1);
    end else if (!step_done) begin
      timer_reg <= timer_reg - 16'h0001;
    end
  end

  // fault latch: set wins, cleared only by releasing the supply command
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fault_reg <= 1'b0;
    end else if (fault_hit) begin
      fault_reg <= 1'b1;
    end else if (cmd_n) begin
      fault_reg <= 1'b0;
    end
  end

  // ****************************************
  // card supply, voltage, reset
  // ****************************************
  logic io_en;
  logic clk_en;
  logic rst_en;

  assign io_en  = (state_reg == ST_IO) || (state_reg == ST_CLK) ||
                  (state_reg == ST_ON) || (state_reg == ST_DRST) || (state_reg == ST_DCLK);
  assign clk_en = (state_reg == ST_CLK) || (state_reg == ST_ON) || (state_reg == ST_DRST);
  assign rst_en = (state_reg == ST_ON);

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_card_supply_on  <= 1'b0;
      o_card_voltage_5v <= 1'b1;
    end else begin
      o_card_supply_on <= (state_next != ST_OFF) && (state_next != ST_HOLD);
      if (state_reg == ST_OFF) begin
        o_card_voltage_5v <= vsel;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_card_reset <= 1'b0;
    end else begin
      o_card_reset <= rst_en && rst_cmd;
    end
  end

  // ****************************************
  // card clock
  // ****************************************
  scif_clkdiv u_clkdiv (
    .i_clock      (i_clock),
    .i_rst_n      (i_rst_n),
    .i_osc        (osc),
    .i_ratio      (ratio),
    .i_enable     (clk_en),
    .i_halt       (halt && in_session),
    .i_halt_level (halt_lvl),
    .o_card_clock (o_card_clock)
  );

  // ****************************************
  // interrupt line
  // ****************************************
  assign o_interrupt_n = 1'b0;

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_interrupt_n_oe <= 1'b0;
    end else if (cmd_n) begin
      o_interrupt_n_oe <= !present;
    end else begin
      o_interrupt_n_oe <= fault_reg || fault_hit;
    end
  end

  // ****************************************
  // line relays
  // ****************************************
  assign o_host_lines = '0;
  assign o_card_lines = '0;

  for (genvar gi = 0; gi < `SCIF_LINES; gi++) begin : g_relay
    scif_relay_e rly_reg;
    scif_relay_e rly_next;
    logic        host_oe_reg;
    logic        card_oe_reg;

    always_comb begin
      rly_next = rly_reg;
      unique case (rly_reg)
        RLY_IDLE:   if (io_en && !host_in[gi]) rly_next = RLY_H2C;
                    else if (io_en && !card_in[gi]) rly_next = RLY_C2H;
        RLY_H2C:    if (host_in[gi] || !io_en) rly_next = RLY_SETTLE;
        RLY_C2H:    if (card_in[gi] || !io_en) rly_next = RLY_SETTLE;
        RLY_SETTLE: if ((host_in[gi] && card_in[gi]) || !io_en) rly_next = RLY_IDLE;
      endcase
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
        rly_reg     <= RLY_IDLE;
        host_oe_reg <= 1'b0;
        card_oe_reg <= 1'b0;
      end else begin
        rly_reg     <= rly_next;
        card_oe_reg <= (rly_next == RLY_H2C);
        host_oe_reg <= (rly_next == RLY_C2H);
      end
    end

    assign o_host_lines_oe[gi] = host_oe_reg;
    assign o_card_lines_oe[gi] = card_oe_reg;
  end

  // ****************************************
  // event stream
  // ****************************************
  scif_evt_if src_evt ();
  scif_evt_if out_evt ();
  logic       ev_req_reg;
  scif_evt_e  ev_code_reg;
  logic       ev_new;
  scif_evt_e  ev_new_code;

  always_comb begin
    ev_new      = 1'b1;
    ev_new_code = EV_CARD_IN;
    if (fault_hit && !fault_reg) begin
      ev_new_code = !present ? EV_CARD_OUT :
                    volt_flt ? EV_VOLT_FAULT :
                    therm_flt ? EV_THERM_FAULT : EV_CURR_FAULT;
    end else if (present && !present_prev_reg) begin
      ev_new_code = EV_CARD_IN;
    end else if (!present && present_prev_reg) begin
      ev_new_code = EV_CARD_OUT;
    end else if (state_next == ST_ON && state_reg == ST_CLK) begin
      ev_new_code = EV_ACTIVE;
    end else if (state_reg == ST_DVCC && state_next != ST_DVCC) begin
      ev_new_code = EV_DEACTIVE;
    end else begin
      ev_new = 1'b0;
    end
  end

  // pending event waits for buffer room; newcomers while blocked are dropped
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ev_req_reg  <= 1'b0;
      ev_code_reg <= EV_CARD_IN;
    end else if (!ev_req_reg || src_evt.ready) begin
      ev_req_reg  <= ev_new;
      ev_code_reg <= ev_new_code;
    end
  end

  assign src_evt.valid = ev_req_reg;
  assign src_evt.code  = ev_code_reg;
  assign out_evt.ready = i_event_ready;
  assign o_event_valid = out_evt.valid;
  assign o_event_code  = out_evt.code;

  scif_buf u_buf (
    .i_clock (i_clock),
    .i_rst_n (i_rst_n),
    .in_evt  (src_evt.snk),
    .out_evt (out_evt.src)
  );
endmodule : scif_top
`default_nettype wire
